// file: dv/lstx_mode_ctl_properties.sv
// assertion checker for the low-swing transmit mode control
`include "lstx_defs.vh"

module lstx_mode_ctl_checker
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEnable,
  // register port
  input wire logic [`LSTX_ADDR_W-1:0] regAddr,
  input wire logic [`LSTX_DATA_W-1:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [`LSTX_DATA_W-1:0] regReadData,
  // link state
  input wire logic [`LSTX_LTSSM_W-1:0] ltssmState,
  // transmitter controls
  input wire logic txLowSwing,
  input wire logic txDeemphEnable,
  input wire logic txDeemphSel,
  input wire logic [`LSTX_LANES*`LSTX_DL_W-1:0] txDriveLevel,
  input wire logic txMarginActive,
  input wire logic txMarginLowSwing,
  input wire logic [`LSTX_TM_W-1:0] txMarginLevel,
  input wire logic linkRetrainRequest
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire logic inComp = ltssmState == `LSTX_LTSSM_POLL_COMPLIANCE;
  wire logic inLock = ltssmState == `LSTX_LTSSM_RECOVERY_RCVRLOCK;

  sequence s_enable_write;
    regWrite && clkEnable && regAddr == `LSTX_OFS_SERDES_CFG && regWriteData[0] && !inComp;
  endsequence
  sequence s_comp_entry;
    inComp && !$past(inComp) && txLowSwing;
  endsequence

  a_enable_write: assert property (s_enable_write ##1 !inComp |=> txLowSwing)
    else $error("low swing not entered after enable");
  a_full_no_code: assert property (!txLowSwing |-> txDriveLevel == 16'h0000)
    else $error("drive code present in full swing");
  a_reset_full: assert property ($fell(reset) |-> !txLowSwing && txDeemphEnable)
    else $error("not full swing out of reset");
  a_deemph_off: assert property (txLowSwing |-> !txDeemphEnable && !txDeemphSel)
    else $error("de-emphasis active in low swing");
  a_status_masked: assert property (regRead && regAddr == `LSTX_OFS_LINK_STATUS_TWO ##1 txLowSwing
    |-> regReadData[1:0] == 2'h0)
    else $error("de-emphasis status shown in low swing");
  a_comp_lowswing: assert property (s_comp_entry ##1 inComp
    |=> txMarginActive && txMarginLowSwing && !txDeemphEnable)
    else $error("compliance entry did not apply low-swing margin");
  a_margin_hold: assert property ((!inComp && !inLock) [*2] |=> $stable(txMarginLevel))
    else $error("margin changed outside a margin state");
  a_retrain_cause: assert property (regWrite && clkEnable && regAddr == `LSTX_OFS_LINK_CONTROL
    && regWriteData[`LSTX_BIT_RETRAIN] |-> ##[1:2] linkRetrainRequest)
    else $error("retrain write gave no pulse");
  a_retrain_single: assert property (linkRetrainRequest |=> !linkRetrainRequest)
    else $error("retrain pulse longer than one cycle");
endmodule // lstx_mode_ctl_checker

bind lstx_mode_ctl lstx_mode_ctl_checker u_checker
(
  .clk_sys(clk_sys), .reset(reset), .clkEnable(clkEnable), .regAddr(regAddr),
  .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
  .ltssmState(ltssmState), .txLowSwing(txLowSwing), .txDeemphEnable(txDeemphEnable),
  .txDeemphSel(txDeemphSel), .txDriveLevel(txDriveLevel), .txMarginActive(txMarginActive),
  .txMarginLowSwing(txMarginLowSwing), .txMarginLevel(txMarginLevel),
  .linkRetrainRequest(linkRetrainRequest)
);

// file: dv/lstx_phy_model.sv
// behavioural link state and speed source standing in for the physical layer
`include "lstx_defs.vh"

module lstx_phy_model
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // commands from the bench
  input wire logic goCompliance,
  input wire logic goRecovery,
  input wire logic gen2Sel,
  // link state toward the block
  output logic [`LSTX_LTSSM_W-1:0] ltssmState,
  output logic linkSpeedGen2,
  output logic phyCurDeemph
);
  timeunit 1ns;
  timeprecision 1ps;
  parameter logic [`LSTX_LTSSM_W-1:0] LINK_UP = 6'h11;

  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      ltssmState <= LINK_UP;
      linkSpeedGen2 <= 1'b0;
      phyCurDeemph <= 1'b0;
    end
    else
    begin
      ltssmState <= goCompliance ? `LSTX_LTSSM_POLL_COMPLIANCE :
        goRecovery ? `LSTX_LTSSM_RECOVERY_RCVRLOCK : LINK_UP;
      linkSpeedGen2 <= gen2Sel;
      // keeps moving so a stale status cannot pass for a masked one
      phyCurDeemph <= ~phyCurDeemph;
    end
  end
endmodule // lstx_phy_model

// file: dv/testbench.sv
// self-checking testbench for the low-swing transmit mode control
`include "lstx_defs.vh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset, clkEnable, regWrite, regRead, goCompliance, goRecovery, gen2Sel;
  logic [7:0] regAddr;
  logic [31:0] regWriteData, regReadData;
  logic [5:0] ltssmState;
  logic linkSpeedGen2, phyCurDeemph, txLowSwing, txDeemphEnable, txDeemphSel;
  logic txMarginActive, txMarginLowSwing, linkRetrainRequest;
  logic [15:0] txDriveLevel;
  logic [2:0] txMarginLevel;
  int errors = 0;
  int samplesChecked = 0;

  lstx_mode_ctl DUT (.clk_sys(clk_sys), .reset(reset), .clkEnable(clkEnable), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .ltssmState(ltssmState), .linkSpeedGen2(linkSpeedGen2), .phyCurDeemph(phyCurDeemph),
    .txLowSwing(txLowSwing), .txDeemphEnable(txDeemphEnable), .txDeemphSel(txDeemphSel),
    .txDriveLevel(txDriveLevel), .txMarginActive(txMarginActive), .txMarginLowSwing(txMarginLowSwing),
    .txMarginLevel(txMarginLevel), .linkRetrainRequest(linkRetrainRequest));
  lstx_phy_model phyModel (.clk_sys(clk_sys), .reset(reset), .goCompliance(goCompliance),
    .goRecovery(goRecovery), .gen2Sel(gen2Sel), .ltssmState(ltssmState),
    .linkSpeedGen2(linkSpeedGen2), .phyCurDeemph(phyCurDeemph));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task tally_and_finish;
    $display("comparisons %0d, mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samplesChecked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 chk(regReadData, exp, what);
  endtask

  // two register stages plus the link model's own flop
  task settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task test_reset;
    rd(`LSTX_OFS_SERDES_CFG, 32'h00000000, "enable at reset");
    rd(`LSTX_OFS_LANE_TX_CONTROL_ONE, 32'h77777777, "levels at reset");
    chk(txLowSwing, 1'b0, "swing at reset");
    chk(txDeemphEnable, 1'b1, "de-emphasis at reset");
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h00000000, "unmapped read");
    $display("test_reset done");
  endtask

  task test_freeze;
    @(posedge clk_sys);
    clkEnable <= 1'b0;
    wr(`LSTX_OFS_SERDES_CFG, 32'h00000001);
    settle;
    chk(txLowSwing, 1'b0, "frozen while disabled");
    @(posedge clk_sys);
    clkEnable <= 1'b1;
    rd(`LSTX_OFS_SERDES_CFG, 32'h00000000, "write dropped while frozen");
    $display("test_freeze done");
  endtask

  task test_levels;
    wr(`LSTX_OFS_LINK_CONTROL_TWO, 32'h00001040);
    wr(`LSTX_OFS_LANE_TX_CONTROL_ONE, 32'hF00F5AA5);
    wr(`LSTX_OFS_SERDES_CFG, 32'h00000001);
    settle;
    chk(txLowSwing, 1'b1, "low swing on");
    chk(txDeemphEnable, 1'b0, "de-emphasis forced off");
    chk(txDeemphSel, 1'b0, "choice ignored");
    chk(txDriveLevel, 16'h0FA5, "first speed levels");
    @(posedge clk_sys);
    gen2Sel <= 1'b1;
    settle;
    chk(txDriveLevel, 16'hF05A, "second speed levels");
    rd(`LSTX_OFS_LINK_STATUS_TWO, 32'h00000000, "status masked");
    wr(`LSTX_OFS_LANE_TX_CONTROL_ONE, 32'h0FF00FF0);
    settle;
    chk(txDriveLevel, 16'h0F0F, "rewritten levels");
    @(posedge clk_sys);
    gen2Sel <= 1'b0;
    settle;
    chk(txDriveLevel, 16'hF0F0, "extreme first speed codes");
    wr(`LSTX_OFS_SERDES_CFG, 32'h00000000);
    settle;
    chk(txLowSwing, 1'b0, "low swing off");
    chk(txDeemphSel, 1'b1, "choice back in force");
    chk(txDriveLevel, 16'h0000, "full swing code");
    $display("test_levels done");
  endtask

  task test_compliance;
    wr(`LSTX_OFS_LINK_CONTROL_TWO, 32'h00000280);
    wr(`LSTX_OFS_SERDES_CFG, 32'h00000001);
    settle;
    chk(txMarginLevel, 3'h0, "margin held back");
    @(posedge clk_sys);
    goCompliance <= 1'b1;
    settle;
    chk(txMarginActive, 1'b1, "margin active");
    chk(txMarginLowSwing, 1'b1, "low-swing margin set");
    chk(txMarginLevel, 3'h5, "compliance margin");
    chk(txDeemphEnable, 1'b0, "no compliance de-emphasis");
    rd(`LSTX_OFS_STATUS, 32'h00000037, "status in compliance");
    wr(`LSTX_OFS_SERDES_CFG, 32'h00000000);
    settle;
    chk(txLowSwing, 1'b0, "clear wins in compliance");
    chk(txMarginLowSwing, 1'b0, "margin set follows clear");
    @(posedge clk_sys);
    goCompliance <= 1'b0;
    wr(`LSTX_OFS_LINK_CONTROL_TWO, 32'h00000100);
    settle;
    chk(txMarginLevel, 3'h5, "new margin waits");
    @(posedge clk_sys);
    goRecovery <= 1'b1;
    @(posedge clk_sys);
    goRecovery <= 1'b0;
    settle;
    chk(txMarginLevel, 3'h2, "margin after lock state");
    wr(`LSTX_OFS_LINK_CONTROL, 32'h00000020);
    #1 chk(linkRetrainRequest, 1'b1, "retrain pulse");
    @(posedge clk_sys);
    #1 chk(linkRetrainRequest, 1'b0, "retrain pulse ends");
    wr(`LSTX_OFS_LINK_CONTROL_TWO, 32'h00001000);
    @(posedge clk_sys);
    goCompliance <= 1'b1;
    settle;
    chk(txMarginLowSwing, 1'b0, "full-swing margin set");
    chk(txDeemphSel, 1'b1, "compliance choice in full swing");
    @(posedge clk_sys);
    goCompliance <= 1'b0;
    $display("test_compliance done");
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    $display("wrong value at %0t: run timed out", $time);
    tally_and_finish;
  end

  initial
  begin
    reset = 1'b1;
    clkEnable = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWriteData = 32'h00000000;
    goCompliance = 1'b0;
    goRecovery = 1'b0;
    gen2Sel = 1'b0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    test_reset;
    test_freeze;
    test_levels;
    test_compliance;
    tally_and_finish;
  end
endmodule // testbench

// file: src/lstx_defs.vh
// constants for the low-swing transmit mode control block
`ifndef LSTX_DEFS_VH
`define LSTX_DEFS_VH

// ----------------------------------------------------------------
// register bus shape
// ----------------------------------------------------------------
`define LSTX_ADDR_W 8
`define LSTX_DATA_W 32
`define LSTX_LANES 4

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define LSTX_OFS_SERDES_CFG 8'h00
`define LSTX_OFS_LANE_TX_CONTROL_ONE 8'h04
`define LSTX_OFS_LINK_CONTROL_TWO 8'h08
`define LSTX_OFS_LINK_CONTROL 8'h0C
`define LSTX_OFS_LINK_STATUS_TWO 8'h10
`define LSTX_OFS_STATUS 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LSTX_BIT_LOW_SWING_ENABLE 0
`define LSTX_LANE_FIELD_W 8
`define LSTX_DL_W 4
`define LSTX_DL_GEN1_LSB 0
`define LSTX_DL_GEN2_LSB 4
`define LSTX_TM_LSB 7
`define LSTX_TM_W 3
`define LSTX_BIT_SELECTABLE_DEEMPH 6
`define LSTX_BIT_COMPLIANCE_DEEMPH 12
`define LSTX_BIT_RETRAIN 5
`define LSTX_BIT_CUR_DEEMPH 0
`define LSTX_BIT_CUR_DEEMPH_VALID 1
`define LSTX_ST_BIT_LOW_SWING 0
`define LSTX_ST_BIT_COMPLIANCE 1
`define LSTX_ST_MARGIN_LSB 2
`define LSTX_ST_BIT_MARGIN_ACTIVE 5
`define LSTX_ST_BIT_DEEMPH_EN 6

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define LSTX_RST_SERDES_CFG 1'b0
`define LSTX_RST_DRIVE_LEVEL 4'h7
`define LSTX_RST_TM 3'h0
`define LSTX_RST_DEEMPH_CHOICE 1'h0
`define LSTX_RST_DEEMPH_EN 1'h1
`define LSTX_TM_NORMAL 3'h0
`define LSTX_DL_MIN 4'h0
`define LSTX_DL_MAX 4'hF
`define LSTX_LTSSM_W 6
`define LSTX_LTSSM_POLL_COMPLIANCE 6'h03
`define LSTX_LTSSM_RECOVERY_RCVRLOCK 6'h0B

`endif

// file: src/lstx_mode_ctl.v
// low-swing transmitter mode control for one switch port
//
// Contract
// - transmitter goes low-swing only while software holds the low-swing enable bit set.
// - low-swing enable bit resets cleared, so full swing is the default.
// - low-swing enabled means reduced drive and de-emphasis forced off; here an enable set after a full-swing compliance entry waits for exit.
// - selectable and compliance de-emphasis choices have no effect while low-swing is on.
// - current de-emphasis status is invalid while low-swing is on.
// - low-swing swing comes from the Gen1 or Gen2 drive-level field by link speed.
// - Gen1 low-swing drive level accepts 0x00..0x0F, swing rising with the code.
// - Gen2 low-swing drive level accepts 0x00..0x0F, swing rising with the code.
// - compliance entry with low-swing on uses the margin field's low-swing level set.
// - compliance entry with low-swing on applies no de-emphasis.
// - new margin selection applies only when passing a margin-change state; retrain advised.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`include "lstx_defs.vh"

module lstx_mode_ctl
(
  // clock, reset, enable
  input wire clk_sys,
  input wire reset,
  input wire clkEnable,
  // register port
  input wire [`LSTX_ADDR_W-1:0] regAddr,
  input wire [`LSTX_DATA_W-1:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  output reg [`LSTX_DATA_W-1:0] regReadData,
  // physical layer state (same clock domain)
  input wire [`LSTX_LTSSM_W-1:0] ltssmState,
  input wire linkSpeedGen2,
  input wire phyCurDeemph,
  // transmitter controls
  output reg txLowSwing,
  output reg txDeemphEnable,
  output reg txDeemphSel,
  output reg [`LSTX_LANES*`LSTX_DL_W-1:0] txDriveLevel,
  output reg txMarginActive,
  output reg txMarginLowSwing,
  output reg [`LSTX_TM_W-1:0] txMarginLevel,
  // retrain request to the link state machine
  output reg linkRetrainRequest
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [1:0] ST_NORMAL = 2'b01;
  localparam [1:0] ST_COMPLIANCE = 2'b10;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function hitOffset;
    input [`LSTX_ADDR_W-1:0] addr;
    input [`LSTX_ADDR_W-1:0] ofs;
    begin
      hitOffset = (addr == ofs);
    end
  endfunction

  // picks the lane's 4-bit low-swing code for the running speed
  function [`LSTX_DL_W-1:0] laneLevel;
    input [`LSTX_LANE_FIELD_W-1:0] field;
    input gen2;
    begin
      if (gen2)
      begin
        laneLevel = field[`LSTX_DL_GEN2_LSB +: `LSTX_DL_W];
      end
      else
      begin
        laneLevel = field[`LSTX_DL_GEN1_LSB +: `LSTX_DL_W];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg lowSwingEnable;
  reg [`LSTX_LANES*`LSTX_LANE_FIELD_W-1:0] laneTxControlOne;
  reg [`LSTX_TM_W-1:0] transmitMarginSelect;
  reg selectableDeemphChoice;
  reg complianceDeemphChoice;
  reg [`LSTX_TM_W-1:0] appliedMargin;
  reg [1:0] state;
  reg [1:0] next_state;
  reg complianceLowSwing;

  wire writeCfg = regWrite && hitOffset(regAddr, `LSTX_OFS_SERDES_CFG);
  wire writeLane = regWrite && hitOffset(regAddr, `LSTX_OFS_LANE_TX_CONTROL_ONE);
  wire writeLinkCtl2 = regWrite && hitOffset(regAddr, `LSTX_OFS_LINK_CONTROL_TWO);
  wire writeLinkCtl = regWrite && hitOffset(regAddr, `LSTX_OFS_LINK_CONTROL);

  wire inCompliance = (ltssmState == `LSTX_LTSSM_POLL_COMPLIANCE);
  wire inMarginWindow = (ltssmState == `LSTX_LTSSM_RECOVERY_RCVRLOCK);
  wire enterCompliance = inCompliance && state[0];

  // ----------------------------------------------------------------
  // software writes
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    // reset waits for the enable too, so a frozen block holds every flop
    if (clkEnable)
    begin
      if (reset)
      begin
        lowSwingEnable <= `LSTX_RST_SERDES_CFG;
        laneTxControlOne <= {(`LSTX_LANES*2){`LSTX_RST_DRIVE_LEVEL}};
        transmitMarginSelect <= `LSTX_RST_TM;
        selectableDeemphChoice <= `LSTX_RST_DEEMPH_CHOICE;
        complianceDeemphChoice <= `LSTX_RST_DEEMPH_CHOICE;
      end
      else
      begin
        // a merged port needs this bit in both halves; nothing here checks it
        if (writeCfg)
        begin
          lowSwingEnable <= regWriteData[`LSTX_BIT_LOW_SWING_ENABLE];
        end
        if (writeLane)
        begin
          // full 4-bit codes stored untouched; every code is legal
          laneTxControlOne <= regWriteData[`LSTX_LANES*`LSTX_LANE_FIELD_W-1:0];
        end
        if (writeLinkCtl2)
        begin
          transmitMarginSelect <= regWriteData[`LSTX_TM_LSB +: `LSTX_TM_W];
          selectableDeemphChoice <= regWriteData[`LSTX_BIT_SELECTABLE_DEEMPH];
          complianceDeemphChoice <= regWriteData[`LSTX_BIT_COMPLIANCE_DEEMPH];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // retrain request: one-cycle pulse on a write of one
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (clkEnable)
    begin
      if (reset)
      begin
        linkRetrainRequest <= 1'b0;
      end
      else
      begin
        linkRetrainRequest <= writeLinkCtl && regWriteData[`LSTX_BIT_RETRAIN];
      end
    end
  end

  // ----------------------------------------------------------------
  // margin take-over
  // ----------------------------------------------------------------
  // the programmed margin sits idle until the link passes a state
  // where the line level may change; a retrain gets it there quickly
  always @(posedge clk_sys)
  begin
    if (clkEnable)
    begin
      if (reset)
      begin
        appliedMargin <= `LSTX_RST_TM;
      end
      else
      begin
        if (inMarginWindow || enterCompliance)
        begin
          appliedMargin <= transmitMarginSelect;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // compliance tracking
  // ----------------------------------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      ST_NORMAL:
      begin
        if (inCompliance)
        begin
          next_state = ST_COMPLIANCE;
        end
      end
      ST_COMPLIANCE:
      begin
        if (!inCompliance)
        begin
          next_state = ST_NORMAL;
        end
      end
      default:
      begin
        next_state = ST_NORMAL;
      end
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (clkEnable)
    begin
      if (reset)
      begin
        state <= ST_NORMAL;
        complianceLowSwing <= 1'b0;
      end
      else
      begin
        state <= next_state;
        // swing set is fixed at entry; a later enable waits for exit
        if (enterCompliance)
        begin
          complianceLowSwing <= lowSwingEnable;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // transmitter controls
  // ----------------------------------------------------------------
  wire complianceNow = state[1];
  wire [`LSTX_LANES*`LSTX_DL_W-1:0] laneLevels;
  reg lowSwingNow;

  // low swing always needs the enable bit; inside compliance the set
  // chosen at entry holds too, so a late enable cannot switch sets
  always @*
  begin
    lowSwingNow = lowSwingEnable;
    if (complianceNow && !complianceLowSwing)
    begin
      lowSwingNow = 1'h0;
    end
  end

  genvar lane;
  generate
    for (lane = 0; lane < `LSTX_LANES; lane = lane + 1)
    begin : gLane
      // continuous selection: a rewrite reaches the lane next cycle
      assign laneLevels[lane*`LSTX_DL_W +: `LSTX_DL_W] =
        laneLevel(laneTxControlOne[lane*`LSTX_LANE_FIELD_W +: `LSTX_LANE_FIELD_W], linkSpeedGen2);
    end
  endgenerate

  always @(posedge clk_sys)
  begin
    if (clkEnable)
    begin
      if (reset)
      begin
        txLowSwing <= 1'b0;
        txDeemphEnable <= `LSTX_RST_DEEMPH_EN;
        txDeemphSel <= 1'b0;
        txDriveLevel <= {`LSTX_LANES*`LSTX_DL_W{1'b0}};
        txMarginActive <= 1'b0;
        txMarginLowSwing <= 1'b0;
        txMarginLevel <= `LSTX_TM_NORMAL;
      end
      else
      begin
        txLowSwing <= lowSwingNow;
        if (lowSwingNow)
        begin
          // de-emphasis choices are ignored, not merely overridden later
          txDeemphEnable <= 1'b0;
          txDeemphSel <= 1'b0;
          txDriveLevel <= laneLevels;
        end
        else
        begin
          txDeemphEnable <= 1'b1;
          txDeemphSel <= complianceNow ? complianceDeemphChoice : selectableDeemphChoice;
          // full-swing drive comes from tables outside this block
          txDriveLevel <= {`LSTX_LANES*`LSTX_DL_W{1'b0}};
        end
        txMarginActive <= complianceNow || (appliedMargin != `LSTX_TM_NORMAL);
        txMarginLowSwing <= lowSwingNow;
        txMarginLevel <= appliedMargin;
      end
    end
  end

  // ----------------------------------------------------------------
  // read side
  // ----------------------------------------------------------------
  reg [`LSTX_DATA_W-1:0] next_readData;

  always @*
  begin
    next_readData = {`LSTX_DATA_W{1'b0}};
    if (hitOffset(regAddr, `LSTX_OFS_SERDES_CFG))
    begin
      next_readData[`LSTX_BIT_LOW_SWING_ENABLE] = lowSwingEnable;
    end
    else if (hitOffset(regAddr, `LSTX_OFS_LANE_TX_CONTROL_ONE))
    begin
      next_readData[`LSTX_LANES*`LSTX_LANE_FIELD_W-1:0] = laneTxControlOne;
    end
    else if (hitOffset(regAddr, `LSTX_OFS_LINK_CONTROL_TWO))
    begin
      next_readData[`LSTX_TM_LSB +: `LSTX_TM_W] = transmitMarginSelect;
      next_readData[`LSTX_BIT_SELECTABLE_DEEMPH] = selectableDeemphChoice;
      next_readData[`LSTX_BIT_COMPLIANCE_DEEMPH] = complianceDeemphChoice;
    end
    else if (hitOffset(regAddr, `LSTX_OFS_LINK_STATUS_TWO))
    begin
      // status is meaningless in low swing: shown as zero, valid clear
      next_readData[`LSTX_BIT_CUR_DEEMPH] = phyCurDeemph && !lowSwingNow;
      next_readData[`LSTX_BIT_CUR_DEEMPH_VALID] = !lowSwingNow;
    end
    else if (hitOffset(regAddr, `LSTX_OFS_STATUS))
    begin
      next_readData[`LSTX_ST_BIT_LOW_SWING] = txLowSwing;
      next_readData[`LSTX_ST_BIT_COMPLIANCE] = complianceNow;
      next_readData[`LSTX_ST_MARGIN_LSB +: `LSTX_TM_W] = appliedMargin;
      next_readData[`LSTX_ST_BIT_MARGIN_ACTIVE] = txMarginActive;
      next_readData[`LSTX_ST_BIT_DEEMPH_EN] = txDeemphEnable;
    end
  end

  always @(posedge clk_sys)
  begin
    if (clkEnable)
    begin
      if (reset)
      begin
        regReadData <= {`LSTX_DATA_W{1'b0}};
      end
      else
      begin
        regReadData <= regRead ? next_readData : {`LSTX_DATA_W{1'b0}};
      end
    end
  end

endmodule // lstx_mode_ctl
